//--- rtl/standby_timer_pkg.sv
package standby_timer_pkg;

	// ==========================================================
	// Command opcodes and timeout codes
	localparam logic [7:0] OP_STANDBY     = 8'he2;
	localparam logic [7:0] OP_STANDBY_ALT = 8'h96;
	localparam logic [7:0] CODE_OFF       = 8'h00;
	localparam logic [7:0] CODE_5S_MAX    = 8'hf0;
	localparam logic [7:0] CODE_30M_MAX   = 8'hfb;
	localparam logic [7:0] CODE_21M       = 8'hfc;
	localparam logic [7:0] CODE_8H        = 8'hfd;
	localparam logic [7:0] CODE_ABORT     = 8'hfe;
	localparam logic [7:0] CODE_30M_BASE  = 8'hf0;

	// ==========================================================
	// Timing: the countdown runs in ticks of TICK_S seconds
	localparam int        CLK_HZ       = 200_000_000;
	localparam int        TICK_S       = 5;
	localparam int        TICK_CYCLES  = TICK_S * CLK_HZ;
	localparam int        STEP_30M_S   = 1800;
	localparam int        T_21M_S      = 1260;
	localparam int        T_8H_S       = 28800;
	localparam int        T_21M15_S    = 1275;
	localparam int        TICKS_W      = 13;
	localparam logic [TICKS_W-1:0] STEP_30M_TICKS = TICKS_W'(STEP_30M_S / TICK_S);
	localparam logic [TICKS_W-1:0] T_21M_TICKS    = TICKS_W'(T_21M_S / TICK_S);
	localparam logic [TICKS_W-1:0] T_8H_TICKS     = TICKS_W'(T_8H_S / TICK_S);
	localparam logic [TICKS_W-1:0] T_21M15_TICKS  = TICKS_W'(T_21M15_S / TICK_S);

	// ==========================================================
	// Completion status and error values
	localparam logic [7:0] STAT_OK    = 8'h50;
	localparam logic [7:0] STAT_ERR   = 8'h51;
	localparam logic [7:0] ERR_NONE   = 8'h00;
	localparam logic [7:0] ERR_ABORT  = 8'h04;

	// ==========================================================
	// Reset values
	localparam logic [TICKS_W-1:0] RST_TICKS = '0;

	typedef enum logic [1:0] {
		PWR_ACTIVE    = 2'b00,
		PWR_STANDBY   = 2'b01,
		PWR_STANDBY_Z = 2'b10
	} pwr_cond_t;

	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_ANSWER    = 3'b001,
		ST_SPIN_DOWN = 3'b010,
		ST_STANDBY   = 3'b011,
		ST_SPIN_UP   = 3'b100
	} seq_state_t;

	typedef struct packed {
		logic [7:0] opcode;
		logic [7:0] sector_count;
	} host_cmd_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] error;
	} cmd_resp_t;

endpackage : standby_timer_pkg

//--- rtl/standby_power_down_timer.sv
// Summary of operation
// - Standby command enters standby at once and loads timeout from sector count.
// - Entering standby spins spindle down, interface stays up; skip if stopped.
// - In standby commands still accepted; non-standby commands complete only once the spindle is at speed.
// - Countdown runs only after the drive is back in idle.
// - With extended power conditions on, standby means the deepest standby.
// - Nonzero timeout code enables auto power-down; zero disables the timer.
// - Codes 1..240 give code*5 s; 241..251 give (code-240)*30 min.
// - 252 is 21 min, 253 is 8 h, 255 is 21 min 15 s; 254 aborts.
// - Timer expiry without host access forces standby.
// - Any host access before expiry reloads the full interval.
`timescale 1ns/1ps
`default_nettype none

module standby_power_down_timer #(
	parameter int TICK_CYCLES = standby_timer_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic                         clock,
	input  wire logic                         sys_rst,
	// Command block write
	input  wire logic                         cmd_valid,
	input  wire standby_timer_pkg::host_cmd_t cmd,
	input  wire logic                         host_access,
	// Feature and spindle state
	input  wire logic                         epc_enable,
	input  wire logic                         spindle_stopped,
	input  wire logic                         spindle_at_speed,
	// Completion
	output var  logic                         cmd_done,
	output var  standby_timer_pkg::cmd_resp_t resp,
	output var  logic                         busy,
	// Power and spindle control
	output var  logic                         spin_down_req,
	output var  logic                         spin_up_req,
	output var  standby_timer_pkg::pwr_cond_t pwr_cond,
	output var  logic                         timer_enabled
);

	localparam int TW = standby_timer_pkg::TICKS_W;

	// ==========================================================
	// Timeout decode
	function automatic logic [TW-1:0] code_ticks(input logic [7:0] code);
		logic [TW-1:0] t;
		t = standby_timer_pkg::RST_TICKS;
		if (code == standby_timer_pkg::CODE_OFF) begin
			t = standby_timer_pkg::RST_TICKS;
		end else if (code <= standby_timer_pkg::CODE_5S_MAX) begin
			t = TW'(code);
		end else if (code <= standby_timer_pkg::CODE_30M_MAX) begin
			t = TW'(TW'(code - standby_timer_pkg::CODE_30M_BASE)
				* standby_timer_pkg::STEP_30M_TICKS);
		end else if (code == standby_timer_pkg::CODE_21M) begin
			t = standby_timer_pkg::T_21M_TICKS;
		end else if (code == standby_timer_pkg::CODE_8H) begin
			t = standby_timer_pkg::T_8H_TICKS;
		end else begin
			t = standby_timer_pkg::T_21M15_TICKS;
		end
		return t;
	endfunction : code_ticks

	function automatic logic is_standby_op(input logic [7:0] op);
		return (op == standby_timer_pkg::OP_STANDBY) || (op == standby_timer_pkg::OP_STANDBY_ALT);
	endfunction : is_standby_op

	// ==========================================================
	// State
	standby_timer_pkg::seq_state_t state_q, state_d;
	standby_timer_pkg::pwr_cond_t  pwr_q, pwr_d;
	standby_timer_pkg::cmd_resp_t  resp_q, resp_d;
	logic [TW-1:0] reload_q, reload_d;
	logic [TW-1:0] ticks_q, ticks_d;
	logic [31:0]   sub_q, sub_d;
	logic          enabled_q, enabled_d;
	logic          done_q, done_d;
	logic          pend_q, pend_d;
	logic          down_q, down_d;
	logic          up_q, up_d;
	logic          busy_q;

	// ==========================================================
	// Decode of the incoming command
	wire logic accept     = cmd_valid && (state_q == standby_timer_pkg::ST_IDLE
		|| state_q == standby_timer_pkg::ST_STANDBY);
	wire logic std_cmd    = accept && is_standby_op(cmd.opcode);
	wire logic abort_cmd  = std_cmd && (cmd.sector_count == standby_timer_pkg::CODE_ABORT);
	wire logic good_std   = std_cmd && !abort_cmd;
	wire logic other_cmd  = accept && !std_cmd;
	wire logic [TW-1:0] new_ticks = code_ticks(cmd.sector_count);
	wire standby_timer_pkg::pwr_cond_t sb_cond = epc_enable ?
		standby_timer_pkg::PWR_STANDBY_Z : standby_timer_pkg::PWR_STANDBY;

	// Countdown only while idle; access or a command reloads it
	wire logic counting   = enabled_q && (state_q == standby_timer_pkg::ST_IDLE);
	wire logic reload     = host_access || cmd_valid;
	wire logic tick       = counting && (sub_q == 32'(TICK_CYCLES - 1));
	wire logic expire     = tick && (ticks_q == TW'(1)) && !reload && !cmd_valid;

	// Busy is registered from the next state so the pin comes from a flop
	wire logic busy_d     = (state_d == standby_timer_pkg::ST_SPIN_DOWN)
		|| (state_d == standby_timer_pkg::ST_SPIN_UP) || (state_d == standby_timer_pkg::ST_ANSWER);

	// ==========================================================
	// Sequencer
	always_comb begin
		state_d  = state_q;
		pwr_d    = pwr_q;
		resp_d   = resp_q;
		reload_d = reload_q;
		enabled_d = enabled_q;
		done_d   = 1'b0;
		pend_d   = pend_q;
		down_d   = down_q;
		up_d     = up_q;
		case (state_q)
			standby_timer_pkg::ST_IDLE,
			standby_timer_pkg::ST_STANDBY: begin
				if (abort_cmd) begin
					// Timer settings are left untouched on abort
					resp_d.status = standby_timer_pkg::STAT_ERR;
					resp_d.error  = standby_timer_pkg::ERR_ABORT;
					done_d  = 1'b1;
				end else if (good_std) begin
					reload_d  = new_ticks;
					enabled_d = (cmd.sector_count != standby_timer_pkg::CODE_OFF);
					pwr_d     = sb_cond;
					pend_d    = 1'b1;
					if (spindle_stopped) begin
						state_d = standby_timer_pkg::ST_ANSWER;
					end else begin
						down_d  = 1'b1;
						state_d = standby_timer_pkg::ST_SPIN_DOWN;
					end
				end else if (other_cmd && state_q == standby_timer_pkg::ST_STANDBY) begin
					up_d    = 1'b1;
					pend_d  = 1'b1;
					state_d = standby_timer_pkg::ST_SPIN_UP;
				end else if (other_cmd) begin
					pend_d  = 1'b1;
					state_d = standby_timer_pkg::ST_ANSWER;
				end else if (expire) begin
					pwr_d   = sb_cond;
					if (spindle_stopped) begin
						state_d = standby_timer_pkg::ST_STANDBY;
					end else begin
						down_d  = 1'b1;
						state_d = standby_timer_pkg::ST_SPIN_DOWN;
					end
				end
			end
			standby_timer_pkg::ST_SPIN_DOWN: begin
				if (spindle_stopped) begin
					down_d  = 1'b0;
					state_d = pend_q ? standby_timer_pkg::ST_ANSWER
						: standby_timer_pkg::ST_STANDBY;
				end
			end
			standby_timer_pkg::ST_SPIN_UP: begin
				if (spindle_at_speed) begin
					up_d    = 1'b0;
					pwr_d   = standby_timer_pkg::PWR_ACTIVE;
					state_d = standby_timer_pkg::ST_ANSWER;
				end
			end
			standby_timer_pkg::ST_ANSWER: begin
				resp_d.status = standby_timer_pkg::STAT_OK;
				resp_d.error  = standby_timer_pkg::ERR_NONE;
				done_d  = 1'b1;
				pend_d  = 1'b0;
				state_d = (pwr_q == standby_timer_pkg::PWR_ACTIVE) ?
					standby_timer_pkg::ST_IDLE : standby_timer_pkg::ST_STANDBY;
			end
			default: begin
				state_d = standby_timer_pkg::ST_IDLE;
			end
		endcase
	end

	// ==========================================================
	// Countdown
	// Sub-tick count restarts on reload so a full interval follows
	always_comb begin
		ticks_d = ticks_q;
		sub_d   = sub_q;
		if (!counting || reload) begin
			ticks_d = reload_d;
			sub_d   = 32'h0000_0000;
		end else if (tick) begin
			ticks_d = ticks_q - TW'(1);
			sub_d   = 32'h0000_0000;
		end else begin
			sub_d   = sub_q + 32'h0000_0001;
		end
	end

	// ==========================================================
	// Registers
	// One block per register keeps each reset value next to its use
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_q <= standby_timer_pkg::ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pwr_q <= standby_timer_pkg::PWR_ACTIVE;
		end else begin
			pwr_q <= pwr_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			resp_q <= '{status: standby_timer_pkg::STAT_OK, error: standby_timer_pkg::ERR_NONE};
		end else begin
			resp_q <= resp_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reload_q <= standby_timer_pkg::RST_TICKS;
		end else begin
			reload_q <= reload_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ticks_q <= standby_timer_pkg::RST_TICKS;
		end else begin
			ticks_q <= ticks_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sub_q <= 32'h0000_0000;
		end else begin
			sub_q <= sub_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			enabled_q <= 1'b0;
		end else begin
			enabled_q <= enabled_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pend_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			down_q <= 1'b0;
		end else begin
			down_q <= down_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			up_q <= 1'b0;
		end else begin
			up_q <= up_d;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
		end
	end

	// ==========================================================
	// Outputs
	assign cmd_done      = done_q;
	assign resp          = resp_q;
	assign busy          = busy_q;
	assign spin_down_req = down_q;
	assign spin_up_req   = up_q;
	assign pwr_cond      = pwr_q;
	assign timer_enabled = enabled_q;

endmodule : standby_power_down_timer

`default_nettype wire

//--- verification/standby_checker_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// Port checker
module standby_checker #(
	parameter int TICK_CYCLES = 4
) (
	// Clock, reset and inputs
	input wire logic                         clock,
	input wire logic                         sys_rst,
	input wire logic                         cmd_valid,
	input wire standby_timer_pkg::host_cmd_t cmd,
	input wire logic                         host_access,
	input wire logic                         epc_enable,
	input wire logic                         spindle_stopped,
	input wire logic                         spindle_at_speed,
	// Outputs
	input wire logic                         cmd_done,
	input wire standby_timer_pkg::cmd_resp_t resp,
	input wire logic                         busy,
	input wire logic                         spin_down_req,
	input wire logic                         spin_up_req,
	input wire standby_timer_pkg::pwr_cond_t pwr_cond,
	input wire logic                         timer_enabled
);
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	wire take = cmd_valid && !busy;
	wire sby  = take && (cmd.opcode == 8'he2 || cmd.opcode == 8'h96);
	wire ab   = sby && cmd.sector_count == 8'hfe;
	wire go   = sby && cmd.sector_count != 8'hfe;
	wire wake = take && !sby && pwr_cond != 2'b00 && !spindle_at_speed;
	a_abort_resp: assert property (ab |=> cmd_done && resp == 16'h5104)
		else $error("abort response wrong");
	a_enter_standby: assert property (go && !spindle_stopped |=> spin_down_req && busy
		&& pwr_cond == ($past(epc_enable) ? 2'b10 : 2'b01))
		else $error("standby entry wrong");
	a_skip_spindown: assert property (go && spindle_stopped |=> !spin_down_req ##1 cmd_done)
		else $error("spin-down not skipped");
	a_timer_load: assert property (go |=> timer_enabled == ($past(cmd.sector_count) != 8'h00))
		else $error("timer arm wrong");
	a_down_held: assert property (spin_down_req && !spindle_stopped |=> spin_down_req)
		else $error("spin-down dropped early");
	a_wake_spinup: assert property (wake |=> spin_up_req && busy)
		else $error("no spin-up on command");
	a_wait_speed: assert property (spin_up_req |-> busy && !cmd_done)
		else $error("completed before speed");
	a_speed_done: assert property (spin_up_req && spindle_at_speed |=> !spin_up_req
		&& pwr_cond == 2'b00 ##1 cmd_done && resp == 16'h5000)
		else $error("wake completion wrong");
	c_abort: cover property (ab);
	c_wake: cover property (spin_up_req && spindle_at_speed);
	c_expiry: cover property (!cmd_valid ##1 $rose(spin_down_req));
endmodule : standby_checker
bind standby_power_down_timer standby_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
	.host_access(host_access), .epc_enable(epc_enable), .spindle_stopped(spindle_stopped),
	.spindle_at_speed(spindle_at_speed), .cmd_done(cmd_done), .resp(resp), .busy(busy),
	.spin_down_req(spin_down_req), .spin_up_req(spin_up_req), .pwr_cond(pwr_cond),
	.timer_enabled(timer_enabled));
`default_nettype wire

//--- verification/spindle_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================================================
// Spindle motor, settles lag cycles after a request
module spindle_model (
	input  wire logic       clock,
	input  wire logic       spin_down_req,
	input  wire logic       spin_up_req,
	input  wire logic [3:0] lag,
	output var  logic       stopped,
	output var  logic       at_speed
);
	logic [3:0] n_q;
	initial begin
		stopped = 1'b0;
		at_speed = 1'b1;
		n_q = 4'h0;
	end
	// Speed is lost as soon as braking starts, not when it ends
	always @(negedge clock) begin
		n_q <= (spin_down_req || spin_up_req) ? n_q + 4'h1 : 4'h0;
		if (spin_down_req) begin
			at_speed <= 1'b0;
			stopped <= stopped || n_q == lag;
		end
		if (spin_up_req) begin
			stopped <= 1'b0;
			at_speed <= at_speed || n_q == lag;
		end
	end
endmodule : spindle_model
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ====================================================
	// Bench signals
	localparam int TC = 4;
	logic clock = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, host_access = 1'b0;
	logic epc_enable = 1'b0, seen;
	logic [3:0] lag = 4'h0;
	standby_timer_pkg::host_cmd_t cmd = '0;
	standby_timer_pkg::cmd_resp_t resp;
	standby_timer_pkg::pwr_cond_t pwr_cond;
	logic cmd_done, busy, spin_down_req, spin_up_req, timer_enabled, stopped, at_speed;
	int mismatches = 0, n_checks = 0, t;
	logic [7:0] codes [8] = '{8'h00, 8'h03, 8'hf0, 8'hf1, 8'hfb, 8'hfc, 8'hfd, 8'hff};
	int ticks [8] = '{0, 3, 240, 360, 3960, 252, 5760, 255};
	always #2.5 clock = ~clock;
	standby_power_down_timer #(.TICK_CYCLES(TC)) DUT (
		.clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
		.host_access(host_access), .epc_enable(epc_enable), .spindle_stopped(stopped),
		.spindle_at_speed(at_speed), .cmd_done(cmd_done), .resp(resp), .busy(busy),
		.spin_down_req(spin_down_req), .spin_up_req(spin_up_req), .pwr_cond(pwr_cond),
		.timer_enabled(timer_enabled));
	spindle_model spindle (.clock(clock), .spin_down_req(spin_down_req),
		.spin_up_req(spin_up_req), .lag(lag), .stopped(stopped), .at_speed(at_speed));
	// ====================================================
	// Checks and drivers
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic chk_win(input string what, input int lo, input int hi, input int got);
		n_checks++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask : chk_win
	task automatic send(input logic [7:0] op, input logic [7:0] sc);
		@(negedge clock);
		cmd_valid = 1'b1;
		cmd = {op, sc};
		@(negedge clock);
		cmd_valid = 1'b0;
		t = 0;
		while (cmd_done !== 1'b1 && t < 200) begin
			@(negedge clock);
			t++;
		end
		chk("cmd_done", 16'h1, 16'(cmd_done));
	endtask : send
	task automatic s_abort();
		send(8'he2, 8'hfe);
		chk("abort resp", 16'h5104, resp);
		chk("abort state", 16'h0, 16'({pwr_cond, timer_enabled}));
		send(8'hec, 8'h00);
		chk("idle resp", 16'h5000, resp);
		chk("idle pwr", 16'h0, 16'(pwr_cond));
	endtask : s_abort
	// Expiry is judged in a window from one tick early to two ticks late, the prescaler phase is not visible
	task automatic s_timed(input logic [7:0] op, input logic [7:0] code, input int n);
		send(op, code);
		chk("standby resp", 16'h5000, resp);
		chk("standby pwr", epc_enable ? 16'h2 : 16'h1, 16'(pwr_cond));
		chk("armed", 16'(code != 8'h00), 16'(timer_enabled));
		send(8'hec, 8'h00);
		chk("wake resp", 16'h5000, resp);
		chk("wake pwr", 16'h0, 16'(pwr_cond));
		seen = 1'b0;
		repeat (10) begin
			@(negedge clock) host_access = 1'b1;
			seen |= spin_down_req;
			@(negedge clock) host_access = 1'b0;
		end
		chk("reload", 16'h0, 16'(seen));
		t = 0;
		while (spin_down_req !== 1'b1 && t < (n ? 30000 : 200)) begin
			@(negedge clock);
			t++;
		end
		chk_win("expiry", n ? n * TC - TC : 200, n ? n * TC + 2 * TC : 200, t);
		if (n) chk("expiry pwr", epc_enable ? 16'h2 : 16'h1, 16'(pwr_cond));
		while (busy !== 1'b0 && t < 40000) begin
			@(negedge clock);
			t++;
		end
	endtask : s_timed
	task automatic results();
		if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : results
	initial begin
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		chk("reset resp", 16'h5000, resp);
		chk("reset flags", 16'h0, 16'({busy, timer_enabled, pwr_cond, spin_up_req}));
		s_abort();
		for (int i = 0; i < 8; i++) begin
			epc_enable = (i == 1);
			lag = 4'(i);
			s_timed(i[0] ? 8'h96 : 8'he2, codes[i], ticks[i]);
		end
		results();
	end
	initial begin
		#450000;
		mismatches++;
		results();
	end
endmodule : tb_top
`default_nettype wire
